// ---- hdl/pau_top.sv ----
// parallel port unit: port address decode, latches, bit operations
// assumes the core holds req for one cycle and waits for done_q
// Notes on behaviour
// - bit set, clear, test via low index
// - port nine three bits, latches high
// - byte output drives both output ports together
// - decode input, output and bidir port addresses
// - serial buffer and status at 0f, 0e
// - timer and serial controls at 1c,1d,1f
// - transfers with accumulator, memory, immediate
// - output ports released after reset
// - ports four to six high or low
// - ports seven to nine released after reset
// - build option sets initial port levels
// - data memory survives held reset
`timescale 1ns/1ps
`default_nettype none
module pau_top #(
   // one bit per port four..six: 1 gives low after reset
   parameter logic [2:0]   INIT_LOW = 3'b000,
   parameter logic [255:0] TABLE    = {
      128'h1f1e_1d1c_1b1a_1918_1716_1514_1312_1110,
      128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100}
) (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              req,
   input  wire pau_pkg::pau_cmd_t cmd,
   input  wire logic [4:0]        port_addr,
   input  wire logic [3:0]        wdata,
   input  wire logic [1:0]        bit_idx,
   input  wire logic [3:0]        l_index,
   input  wire logic [7:0]        mem_ptr,
   input  wire logic [4:0]        byte_val,
   output logic                   done_q,
   output logic      [3:0]        rdata_q,
   output logic                   test_q,
   input  wire logic [3:0]        in_a_pin,
   output logic      [3:0]        out_low_o,
   output logic      [3:0]        out_low_oe_n,
   output logic      [3:0]        out_high_o,
   output logic      [3:0]        out_high_oe_n,
   input  wire logic [23:0]       bidir_pin_i,
   output logic      [23:0]       bidir_pin_o,
   output logic      [23:0]       bidir_pin_oe_n,
   input  wire logic [3:0]        ser_status_i,
   input  wire logic [3:0]        ser_rx_buf_i,
   output logic                   ser_tx_load_q,
   output logic      [3:0]        ser_tx_data_q,
   output logic      [3:0]        tmr_one_ctl_q,
   output logic      [3:0]        tmr_two_ctl_q,
   output logic      [3:0]        ser_ctl_q
);
   import pau_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // declarations
   pau_state_t  state_q;        // sequencer state
   logic [4:0]  addr_q;         // target port held over memory read
   logic [3:0]  out_low_q;      // low output latch
   logic [3:0]  out_high_q;     // high output latch
   logic [3:0]  bidir_q [6];    // bidir latches, ports four..nine
   logic [3:0]  in_a_m, in_a_s; // input port synchroniser
   logic [23:0] bid_m, bid_s;   // bidir pin synchroniser
   logic [3:0]  ram_q;          // memory read data
   logic [7:0]  lut_q;          // converted byte
   logic        accept;         // request taken this cycle
   logic        is_b;           // index-register bit form
   logic        is_bitwr;       // set or clear of either form
   logic        is_set;         // set of either form
   logic        is_test;        // test of either form
   logic [4:0]  op_addr;        // port the instruction targets
   logic [1:0]  op_bit;         // bit the instruction targets
   logic [3:0]  op_mask;        // one-hot of op_bit
   logic [3:0]  rd_val;         // what an input access returns
   logic [3:0]  lat_val;        // latch behind op_addr
   logic        wr_en;          // a port write happens
   logic [4:0]  wr_addr;        // its address
   logic [3:0]  wr_val;         // its value
   logic        direct;         // finishes in the accept cycle
   logic        ram_we;         // port -> memory write

   // latch-backed port: target of bit writes and latch reads
   function automatic logic is_latch(input logic [4:0] a);
      return (a == PAU_ADDR_OUT_LOW) || (a == PAU_ADDR_OUT_HIGH) ||
             (a >= PAU_ADDR_BIDIR_LO && a <= PAU_ADDR_BIDIR_HI);
   endfunction

   // reset value of bidir latch k
   function automatic logic [3:0] bidir_rst(input int k);
      if (k < PAU_PULLUP_PORTS) begin
         return INIT_LOW[k] ? PAU_LATCH_LOW : PAU_LATCH_REL;
      end else if (k == PAU_NINE_IDX) begin
         return PAU_NINE_MASK;
      end
      return PAU_LATCH_REL;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // instruction decode
   assign accept   = req && (state_q == PAU_ST_IDLE);
   assign is_b     = (cmd == PAU_CMD_SETB) || (cmd == PAU_CMD_CLRB) ||
                     (cmd == PAU_CMD_TESTB);
   assign is_set   = (cmd == PAU_CMD_SET) || (cmd == PAU_CMD_SETB);
   assign is_bitwr = is_set || (cmd == PAU_CMD_CLR) ||
                     (cmd == PAU_CMD_CLRB);
   assign is_test  = (cmd == PAU_CMD_TEST) || (cmd == PAU_CMD_TESTB);
   // index form: upper two bits pick port four..seven, lower the bit
   assign op_addr  = is_b ? PAU_ADDR_BIDIR_LO + {3'b000, l_index[3:2]}
                          : port_addr;
   assign op_bit   = is_b ? l_index[1:0] : bit_idx;
   assign op_mask  = 4'h1 << op_bit;
   assign direct   = (cmd != PAU_CMD_OUT_MEM) && (cmd != PAU_CMD_OUTB);
   assign ram_we   = accept && (cmd == PAU_CMD_IN_MEM);

   ////////////////////////////////////////////////////////////////////
   // read selection: pins for bidir ports, latches for output ports
   always_comb begin
      rd_val  = PAU_UNDEF_READ;  // undefined space reads constant
      lat_val = PAU_LATCH_REL;
      case (op_addr)
         PAU_ADDR_INPUT_A:  rd_val = in_a_s;
         PAU_ADDR_OUT_LOW: begin
            rd_val  = out_low_q;
            lat_val = out_low_q;
         end
         PAU_ADDR_OUT_HIGH: begin
            rd_val  = out_high_q;
            lat_val = out_high_q;
         end
         PAU_ADDR_SER_STAT: rd_val = ser_status_i;
         PAU_ADDR_SER_BUF:  rd_val = ser_rx_buf_i;
         default: begin
            if (op_addr >= PAU_ADDR_BIDIR_LO &&
                op_addr <= PAU_ADDR_BIDIR_HI) begin
               // pin level; only meaningful with latch high
               rd_val  = bid_s[4*(op_addr-PAU_ADDR_BIDIR_LO) +: 4];
               lat_val = bidir_q[3'(op_addr - PAU_ADDR_BIDIR_LO)];
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // port write path; reserved addresses decode to nothing
   assign wr_en   = (state_q == PAU_ST_MEMRD) ||
                    (accept && (cmd == PAU_CMD_OUT_ACC)) ||
                    (accept && is_bitwr && is_latch(op_addr));
   assign wr_addr = (state_q == PAU_ST_MEMRD) ? addr_q : op_addr;
   assign wr_val  = (state_q == PAU_ST_MEMRD) ? ram_q :
                    (cmd == PAU_CMD_OUT_ACC)  ? wdata :
                    is_set ? (lat_val | op_mask) :
                             (lat_val & ~op_mask);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, two stages each
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         in_a_m <= 4'h0;
         in_a_s <= 4'h0;
         bid_m  <= 24'h00_0000;
         bid_s  <= 24'h00_0000;
      end else begin
         in_a_m <= in_a_pin;
         in_a_s <= in_a_m;
         bid_m  <= bidir_pin_i;
         bid_s  <= bid_m;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer: memory-to-port and table paths take one extra cycle
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= PAU_ST_IDLE;
         addr_q  <= 5'h00;
      end else begin
         case (state_q)
            PAU_ST_IDLE: begin
               addr_q <= port_addr;
               if (accept && cmd == PAU_CMD_OUT_MEM) begin
                  state_q <= PAU_ST_MEMRD;
               end else if (accept && cmd == PAU_CMD_OUTB) begin
                  state_q <= PAU_ST_LUT;
               end
            end
            PAU_ST_MEMRD: state_q <= PAU_ST_IDLE;
            PAU_ST_LUT:   state_q <= PAU_ST_IDLE;
            default:      state_q <= PAU_ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // answers to the core
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         done_q  <= 1'b0;
         rdata_q <= 4'h0;
         test_q  <= 1'b0;
      end else begin
         done_q <= (accept && direct) || (state_q != PAU_ST_IDLE);
         if (accept && (cmd == PAU_CMD_IN_ACC ||
                        cmd == PAU_CMD_IN_MEM)) begin
            rdata_q <= rd_val;
         end
         if (accept && is_test) begin
            test_q <= rd_val[op_bit];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output latches: reset releases the sink drivers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         out_low_q  <= PAU_LATCH_REL;
         out_high_q <= PAU_LATCH_REL;
      end else if (state_q == PAU_ST_LUT) begin
         out_low_q  <= lut_q[3:0];
         out_high_q <= lut_q[7:4];
      end else if (wr_en && wr_addr == PAU_ADDR_OUT_LOW) begin
         out_low_q  <= wr_val;
      end else if (wr_en && wr_addr == PAU_ADDR_OUT_HIGH) begin
         out_high_q <= wr_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bidir latches, one per port
   for (genvar k = 0; k < PAU_BIDIR_PORTS; k++) begin : g_bidir
      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            bidir_q[k] <= bidir_rst(k);
         end else if (wr_en && wr_addr == PAU_ADDR_BIDIR_LO + 5'(k)) begin
            // port nine has no bit 3; it stays zero
            bidir_q[k] <= (k == PAU_NINE_IDX) ? (wr_val & PAU_NINE_MASK)
                                              : wr_val;
         end
      end
      // open drain: latch 1 releases, latch 0 sinks
      assign bidir_pin_oe_n[4*k +: 4] = (k == PAU_NINE_IDX) ?
                           (bidir_q[k] | ~PAU_NINE_MASK) : bidir_q[k];
   end

   // sink drivers only ever pull low
   assign bidir_pin_o   = 24'h00_0000;
   assign out_low_o     = 4'h0;
   assign out_high_o    = 4'h0;
   assign out_low_oe_n  = out_low_q;
   assign out_high_oe_n = out_high_q;

   ////////////////////////////////////////////////////////////////////
   // serial and timer control registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ser_tx_load_q <= 1'b0;
         ser_tx_data_q <= PAU_CTL_RST;
         tmr_one_ctl_q <= PAU_CTL_RST;
         tmr_two_ctl_q <= PAU_CTL_RST;
         ser_ctl_q     <= PAU_CTL_RST;
      end else begin
         ser_tx_load_q <= wr_en && wr_addr == PAU_ADDR_SER_BUF;
         if (wr_en && wr_addr == PAU_ADDR_SER_BUF) begin
            ser_tx_data_q <= wr_val;
         end
         if (wr_en && wr_addr == PAU_ADDR_TMR_ONE) begin
            tmr_one_ctl_q <= wr_val;
         end
         if (wr_en && wr_addr == PAU_ADDR_TMR_TWO) begin
            tmr_two_ctl_q <= wr_val;
         end
         if (wr_en && wr_addr == PAU_ADDR_SER_CTL) begin
            ser_ctl_q <= wr_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // memory and conversion table
   pau_ram #(.AW(8), .DW(4)) u_ram (
      .clk_sys (clk_sys),
      .we      (ram_we),
      .waddr   (mem_ptr),
      .wdata   (rd_val),
      .raddr   (mem_ptr),
      .rdata_q (ram_q)
   );

   pau_lut #(.TABLE(TABLE)) u_lut (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .idx     (byte_val),
      .rdata_q (lut_q)
   );

   ////////////////////////////////////////////////////////////////////
   // assertions
   logic first_q;  // high in the first cycle after reset release
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) first_q <= 1'b1;
      else         first_q <= 1'b0;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_rst_out;
      first_q |-> (out_low_oe_n == 4'hf) && (out_high_oe_n == 4'hf);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("out port drive");

   property p_rst_high;
      first_q |-> bidir_pin_oe_n[23:12] == 12'hfff;
   endproperty
   a_rst_high: assert property (p_rst_high) else $error("seven-nine drive");

   property p_rst_low;
      first_q |-> bidir_pin_oe_n[3:0] == {4{~INIT_LOW[0]}};
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("port four init");

   property p_outb;
      accept && cmd == PAU_CMD_OUTB |-> ##2 done_q &&
         {out_high_oe_n, out_low_oe_n} == TABLE[{$past(byte_val,2),3'b000} +: 8];
   endproperty
   a_outb: assert property (p_outb) else $error("byte output value");

   property p_direct;
      accept && cmd == PAU_CMD_OUT_ACC && port_addr == PAU_ADDR_OUT_LOW
         |=> done_q && out_low_oe_n == $past(wdata);
   endproperty
   a_direct: assert property (p_direct) else $error("out low write");

   property p_setb;
      accept && cmd == PAU_CMD_SETB
         |=> bidir_pin_oe_n[4*$past(l_index[3:2]) + $past(l_index[1:0])];
   endproperty
   a_setb: assert property (p_setb) else $error("indexed set");

   property p_tx;
      accept && cmd == PAU_CMD_OUT_ACC && port_addr == PAU_ADDR_SER_BUF
         |=> ser_tx_load_q ##1 !ser_tx_load_q;
   endproperty
   a_tx: assert property (p_tx) else $error("tx load pulse");

   property p_tmr;
      accept && cmd == PAU_CMD_OUT_ACC && port_addr == PAU_ADDR_TMR_TWO
         |=> tmr_two_ctl_q == $past(wdata) && $stable(tmr_one_ctl_q);
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer two control");

   property p_resv;
      accept && cmd == PAU_CMD_OUT_ACC && (port_addr == 5'h03 ||
         port_addr == 5'h1e) |=> $stable({out_low_oe_n, out_high_oe_n,
         bidir_pin_oe_n, ser_ctl_q, tmr_one_ctl_q}) && !ser_tx_load_q;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved write");

   property p_kbit;
      accept && cmd == PAU_CMD_SET && port_addr == PAU_ADDR_INPUT_A
         |=> $stable({out_low_oe_n, out_high_oe_n, bidir_pin_oe_n});
   endproperty
   a_kbit: assert property (p_kbit) else $error("input port bit op");

   property p_nine;
      bidir_pin_oe_n[23];
   endproperty
   a_nine: assert property (p_nine) else $error("port nine bit 3");

   c_outb: cover property (accept && cmd == PAU_CMD_OUTB ##2 done_q);
   c_memout: cover property (accept && cmd == PAU_CMD_OUT_MEM ##2 done_q);
   c_testb: cover property (accept && cmd == PAU_CMD_TESTB ##1 test_q);
   c_inmem: cover property (accept && cmd == PAU_CMD_IN_MEM);

endmodule
`default_nettype wire

// ---- common/pau_pkg.sv ----
// port address unit package: port map, commands, states, reset values
// assumes a 4-bit core that issues one port instruction at a time
package pau_pkg;

   // port address map, as seen by the input/output instructions
   localparam logic [4:0] PAU_ADDR_INPUT_A   = 5'h00;
   localparam logic [4:0] PAU_ADDR_OUT_LOW   = 5'h01;
   localparam logic [4:0] PAU_ADDR_OUT_HIGH  = 5'h02;
   localparam logic [4:0] PAU_ADDR_BIDIR_LO  = 5'h04;
   localparam logic [4:0] PAU_ADDR_BIDIR_HI  = 5'h09;
   localparam logic [4:0] PAU_ADDR_SER_STAT  = 5'h0e;
   localparam logic [4:0] PAU_ADDR_SER_BUF   = 5'h0f;
   localparam logic [4:0] PAU_ADDR_TMR_ONE   = 5'h1c;
   localparam logic [4:0] PAU_ADDR_TMR_TWO   = 5'h1d;
   localparam logic [4:0] PAU_ADDR_SER_CTL   = 5'h1f;

   // geometry
   localparam int         PAU_NIB            = 4;
   localparam int         PAU_BIDIR_PORTS    = 6;
   localparam int         PAU_PULLUP_PORTS   = 3;
   localparam int         PAU_NINE_IDX       = 5;

   // values after reset, and what undefined space reads
   localparam logic [3:0] PAU_LATCH_REL      = 4'hf;
   localparam logic [3:0] PAU_LATCH_LOW      = 4'h0;
   localparam logic [3:0] PAU_NINE_MASK      = 4'h7;
   localparam logic [3:0] PAU_CTL_RST        = 4'h0;
   localparam logic [3:0] PAU_UNDEF_READ     = 4'h0;

   // port instructions from the core
   typedef enum logic [3:0] {
      PAU_CMD_IN_ACC  = 4'h0,  // port -> accumulator
      PAU_CMD_IN_MEM  = 4'h1,  // port -> memory at pointer pair
      PAU_CMD_OUT_ACC = 4'h2,  // accumulator or immediate -> port
      PAU_CMD_OUT_MEM = 4'h3,  // memory at pointer pair -> port
      PAU_CMD_OUTB    = 4'h4,  // 5-bit value -> both output ports
      PAU_CMD_SET     = 4'h5,  // set bit, direct address
      PAU_CMD_CLR     = 4'h6,  // clear bit, direct address
      PAU_CMD_TEST    = 4'h7,  // test bit, direct address
      PAU_CMD_SETB    = 4'h8,  // set bit, low index register
      PAU_CMD_CLRB    = 4'h9,  // clear bit, low index register
      PAU_CMD_TESTB   = 4'ha   // test bit, low index register
   } pau_cmd_t;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      PAU_ST_IDLE  = 3'b001,
      PAU_ST_MEMRD = 3'b010,
      PAU_ST_LUT   = 3'b100
   } pau_state_t;

endpackage

// ---- hdl/pau_ram.sv ----
// data memory of the core, reached here for port <-> memory transfers
// assumes one clock; no reset, so contents survive a held reset
`timescale 1ns/1ps
`default_nettype none
module pau_ram #(
   parameter int AW = 8,
   parameter int DW = 4
) (
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata_q
);

   logic [DW-1:0] mem [2**AW];  // storage, deliberately never cleared

   ////////////////////////////////////////////////////////////////////
   // write port and registered read port
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end

endmodule
`default_nettype wire

// ---- hdl/pau_lut.sv ----
// 5-to-8 conversion table for the byte output instruction
// assumes the table image is fixed at build time like program memory
`timescale 1ns/1ps
`default_nettype none
module pau_lut #(
   // entry i sits in bits 8i+7..8i; default is a plain pass-through
   parameter logic [255:0] TABLE = {
      128'h1f1e_1d1c_1b1a_1918_1716_1514_1312_1110,
      128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100}
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic [4:0] idx,
   output logic      [7:0] rdata_q
);

   logic [7:0] entry;  // selected table word

   assign entry = TABLE[{idx, 3'b000} +: 8];

   ////////////////////////////////////////////////////////////////////
   // registered lookup, one cycle of latency
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= entry;
      end
   end

endmodule
`default_nettype wire

// ---- bench/pau_pins.sv ----
// pin model: open-drain wires of the six two-way ports
// assumes the bench supplies any outside drive per bit
`timescale 1ns/1ps
`default_nettype none
module pau_pins (
   input  wire logic        clk_sys,
   input  wire logic [23:0] oe_n,
   input  wire logic [23:0] ext_en,
   input  wire logic [23:0] ext_val,
   output logic      [23:0] pin
);
   logic tog_q = 1'b0; // floating wire, never settles
   ////////////////////////////////////////////////////////////////////
   // a float must not look like a stable level
   always_ff @(posedge clk_sys) begin
      tog_q <= ~tog_q;
   end
   // sink wins, then outside drive, then pull-up or float
   always_comb begin
      for (int i = 0; i < 24; i++) begin
         if (!oe_n[i]) pin[i] = 1'b0;
         else if (ext_en[i]) pin[i] = ext_val[i];
         else pin[i] = (i < 12) ? 1'b1 : tog_q;
      end
   end
endmodule
`default_nettype wire

// ---- bench/pau_top_bench.sv ----
// self-checking bench for the port address unit
// assumes pau_pkg and the pin model are compiled first
`timescale 1ns/1ps
`default_nettype none
module pau_top_bench;
   import pau_pkg::*;
   localparam logic [23:0] RSTV = 24'hff_ff0f; // port five low
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        req = 1'b0;
   pau_cmd_t    cmd = PAU_CMD_IN_ACC;
   logic [4:0]  port_addr = '0, byte_val = '0;
   logic [3:0]  wdata = '0, l_index = '0, in_a = '0;
   logic [3:0]  ser_st = '0, ser_rx = '0;
   logic [1:0]  bit_idx = '0;
   logic [7:0]  mem_ptr = '0;
   logic [23:0] ext_en = '0, ext_val = '0, pin_i, pin_oe_n;
   logic        done_q, test_q, tx_ld;
   logic [3:0]  rdata_q, lo_oe_n, hi_oe_n, tx_d, t1, t2, sctl;
   logic [3:0]  lat [10];  // expected latches by address
   logic [3:0]  c1, c2, c3; // expected control registers
   logic [11:0] notes [$]; // selector, expected value
   logic [11:0] note;
   logic [31:0] rnd = 32'h4c73_89c3;
   int          err_count = 0;
   int          n_tests = 0;
   ////////////////////////////////////////////////////////////////////
   pau_top #(.INIT_LOW(3'b010)) pau_top_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .cmd(cmd),
      .port_addr(port_addr), .wdata(wdata), .bit_idx(bit_idx),
      .l_index(l_index), .mem_ptr(mem_ptr), .byte_val(byte_val),
      .done_q(done_q), .rdata_q(rdata_q), .test_q(test_q),
      .in_a_pin(in_a), .out_low_o(), .out_low_oe_n(lo_oe_n),
      .out_high_o(), .out_high_oe_n(hi_oe_n), .bidir_pin_i(pin_i),
      .bidir_pin_o(), .bidir_pin_oe_n(pin_oe_n), .ser_status_i(ser_st),
      .ser_rx_buf_i(ser_rx), .ser_tx_load_q(tx_ld), .ser_tx_data_q(tx_d),
      .tmr_one_ctl_q(t1), .tmr_two_ctl_q(t2), .ser_ctl_q(sctl));
   pau_pins pau_pins_inst (.clk_sys(clk_sys), .oe_n(pin_oe_n),
      .ext_en(ext_en), .ext_val(ext_val), .pin(pin_i));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // which output shows the effect of a write to this address
   function automatic logic [3:0] sel_of(input logic [4:0] a);
      case (a)
         5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09: return a[3:0] - 4'h1;
         5'h0f: return 4'h9;
         5'h1c, 5'h1d: return 4'ha;
         5'h1f: return 4'hb;
         default: return 4'h2;
      endcase
   endfunction
   function automatic logic [7:0] exp_of(input logic [3:0] s,
                                         input logic [3:0] d);
      case (s)
         4'h2: return {lat[2], lat[1]};
         4'h9: return {4'h1, d};
         4'ha: return {c1, c2};
         4'hb: return {4'h0, c3};
         default: return {4'h0, lat[s + 4'h1]};
      endcase
   endfunction
   function automatic logic [7:0] obs(input logic [3:0] s);
      case (s)
         4'h0: return {4'h0, rdata_q};
         4'h1: return {7'h0, test_q};
         4'h2: return {hi_oe_n, lo_oe_n};
         4'h9: return {3'h0, tx_ld, tx_d};
         4'ha: return {t1, t2};
         4'hb: return {4'h0, sctl};
         default: return {4'h0, pin_oe_n[4 * (int'(s) - 3) +: 4]};
      endcase
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one instruction; done_q is awaited under a bound
   task automatic op(input pau_cmd_t c, input logic [4:0] a,
                     input logic [3:0] d, input logic [3:0] s,
                     input logic [7:0] e);
      @(posedge clk_sys);
      req <= 1'b1;
      cmd <= c;
      port_addr <= a;
      byte_val <= a;
      wdata <= d;
      bit_idx <= d[1:0];
      l_index <= d;
      mem_ptr <= {d, 4'h5};
      notes.push_back({s, e});
      @(posedge clk_sys);
      req <= 1'b0;
      for (int i = 0; i < 6 && done_q !== 1'b1; i++) @(negedge clk_sys);
      if (done_q !== 1'b1) chk(8'h00, 8'h01);
   endtask
   task automatic do_rst();
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      for (int b = 0; b < 3; b++) begin
         chk(pin_oe_n[8*b +: 8], RSTV[8*b +: 8]);
      end
      chk({hi_oe_n, lo_oe_n}, 8'hff);
      foreach (lat[i]) lat[i] = 4'hf;
      lat[5] = 4'h0;
      {c1, c2, c3} = '0;
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // result watcher: oldest note against the finished instruction
   always @(negedge clk_sys) begin
      if (done_q === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         chk(obs(note[11:8]), note[7:0]);
      end
   end
   initial begin
      #50000;
      err_count++;
      wrap_up();
   end
   initial begin
      logic [3:0] d;
      logic [4:0] v;
      logic [2:0] p;
      do_rst();
      // every address written once, reserved ones included
      for (int a = 0; a < 32; a++) begin
         rnd = lfsr(rnd);
         d = rnd[3:0];
         case (a)
            1, 2, 4, 5, 6, 7, 8: lat[a] = d;
            9: lat[9] = {1'b1, d[2:0]};
            28: c1 = d;
            29: c2 = d;
            31: c3 = d;
            default: ;
         endcase
         op(PAU_CMD_OUT_ACC, 5'(a), d, sel_of(5'(a)),
            exp_of(sel_of(5'(a)), d));
      end
      @(posedge clk_sys);
      rnd = lfsr(rnd);
      in_a <= rnd[3:0];
      ser_st <= rnd[7:4];
      ser_rx <= rnd[11:8];
      ext_en <= 24'h0f_f000;
      ext_val <= {4'h0, rnd[19:12], 12'h0};
      lat[7] = 4'hf;
      op(PAU_CMD_OUT_ACC, 5'h07, 4'hf, 4'h6, 8'h0f);
      lat[4] = 4'h3;
      op(PAU_CMD_OUT_ACC, 5'h04, 4'h3, 4'h3, 8'h03);
      lat[8] = 4'hf;
      op(PAU_CMD_OUT_ACC, 5'h08, 4'hf, 4'h7, 8'h0f);
      repeat (3) @(posedge clk_sys);
      op(PAU_CMD_IN_ACC, 5'h00, 4'h0, 4'h0, {4'h0, rnd[3:0]});
      op(PAU_CMD_IN_ACC, 5'h0e, 4'h0, 4'h0, {4'h0, rnd[7:4]});
      op(PAU_CMD_IN_ACC, 5'h0f, 4'h0, 4'h0, {4'h0, rnd[11:8]});
      op(PAU_CMD_IN_ACC, 5'h07, 4'h0, 4'h0, {4'h0, rnd[15:12]});
      op(PAU_CMD_IN_ACC, 5'h08, 4'h0, 4'h0, {4'h0, rnd[19:16]});
      op(PAU_CMD_IN_ACC, 5'h04, 4'h0, 4'h0, 8'h03);
      op(PAU_CMD_IN_ACC, 5'h01, 4'h0, 4'h0, {4'h0, lat[1]});
      op(PAU_CMD_IN_ACC, 5'h12, 4'h0, 4'h0, {4'h0, PAU_UNDEF_READ});
      // indexed bit set and clear over ports four to seven
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         d = rnd[3:0];
         p = 3'(d[3:2]) + 3'd4;
         lat[p][d[1:0]] = k[0];
         op(k[0] ? PAU_CMD_SETB : PAU_CMD_CLRB, 5'h00, d, 4'(p) - 4'h1,
            {4'h0, lat[p]});
      end
      lat[2][1] = 1'b0;
      op(PAU_CMD_CLR, 5'h02, 4'h1, 4'h2, {lat[2], lat[1]});
      lat[2][3] = 1'b1;
      op(PAU_CMD_SET, 5'h02, 4'h3, 4'h2, {lat[2], lat[1]});
      op(PAU_CMD_TEST, 5'h02, 4'h3, 4'h1, 8'h01);
      op(PAU_CMD_SET, 5'h00, 4'h2, 4'h2, {lat[2], lat[1]});
      repeat (3) @(posedge clk_sys);
      for (int b = 0; b < 4; b++) begin
         op(PAU_CMD_TESTB, 5'h00, 4'(b), 4'h1,
            {7'h0, lat[4][b]});
      end
      // byte output at both ends of the range and one random
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         v = (k == 0) ? 5'h1f : (k == 1) ? 5'h00 : rnd[4:0];
         lat[1] = v[3:0];
         lat[2] = {3'h0, v[4]};
         op(PAU_CMD_OUTB, v, 4'h0, 4'h2, {3'h0, v});
      end
      // memory keeps its word across a reset in mid-run
      op(PAU_CMD_IN_MEM, 5'h0e, 4'h9, 4'h0, {4'h0, ser_st});
      do_rst();
      op(PAU_CMD_OUT_MEM, 5'h01, 4'h9, 4'h2, {4'hf, ser_st});
      wrap_up();
   end
endmodule
`default_nettype wire
